// *** aobs_consts.vh ***
/*
  Constants of the analog output buffer sequencer: register offsets,
  field positions, reset values, buffer geometry and interrupt codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef AOBS_CONSTS_VH
`define AOBS_CONSTS_VH

// ============================================================
// Register byte offsets
`define AOBS_OFF_BUFOPS 8'h00
`define AOBS_OFF_BCTL   8'h04
`define AOBS_OFF_RATE   8'h08
`define AOBS_OFF_DATA   8'h0c
`define AOBS_OFF_STAT   8'h10

// ============================================================
// Buffer operations register fields
`define AOBS_BO_EXT     4
`define AOBS_BO_EN      5
`define AOBS_BO_CIRC    8

// ============================================================
// Board control register fields
`define AOBS_BC_BURST   0
`define AOBS_BC_TRIG    2
`define AOBS_BC_INT_LO  8
`define AOBS_BC_INT_HI  11
`define AOBS_INT_LOQ    4'h3
`define AOBS_INT_BRDY   4'h5

// ============================================================
// Buffer word layout and geometry
`define AOBS_DW_EOF     16
`define AOBS_DW_CHAN    17
`define AOBS_WW         18
`define AOBS_AW         8
`define AOBS_DEPTH      9'h100
`define AOBS_QTR        9'h040

// ============================================================
// Reset values, timing and bus response codes
`define AOBS_BUFOPS_RST 32'h0000_0000
`define AOBS_BCTL_RST   32'h0000_0000
`define AOBS_RATE_RST   16'h0053
`define AOBS_RATE_MIN   16'h0002
`define AOBS_RESP_OK    2'h0
`define AOBS_RESP_ERR   2'h2

`endif

// *** aobs_conv.sv ***
/*
  Converter model at the far side of the sample link.
  Assumes mclk timing; records every word taken, stalls when asked.
*/
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Converter model
module aobs_conv (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        stall_en,
  input  wire logic [15:0] dac_data,
  input  wire logic        dac_chan,
  input  wire logic        dac_valid,
  output var  logic        dac_ready
);
  logic [16:0] got[$];

  // Take words on handshake, drop ready at random when stalling
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      dac_ready <= 1'b0;
      got.delete();
    end else begin
      if (dac_valid && dac_ready) begin
        got.push_back({dac_chan, dac_data});
      end
      dac_ready <= stall_en ? 1'($urandom) : 1'b1;
    end
  end
endmodule

`default_nettype wire

// *** aobs_mem.v ***
/*
  Sample storage of the output buffer: 256 words of 18 bits, one write
  port and one read port whose data come out of a register.
  Assumes one clock and a caller that never reads an unwritten word.
*/
`timescale 1ns/1ps
`default_nettype none

module aobs_mem (
  input  wire        mclk,
  input  wire        reset,
  input  wire        we,
  input  wire [7:0]  waddr,
  input  wire [17:0] wdata,
  input  wire        re,
  input  wire [7:0]  raddr,
  output reg  [17:0] rdata_q
);

  reg [17:0] ram [0:255];

  // ============================================================
  // Write port
  always @(posedge mclk) begin
    if (we) begin
      ram[waddr] <= wdata;
    end
  end

  // ============================================================
  // Registered read port
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_q <= 18'h00000;
    end else if (re) begin
      rdata_q <= ram[raddr];
    end
  end

endmodule

`default_nettype wire

// *** aobs_skid.v ***
/*
  Two-entry buffer with valid and ready on both sides, in front of the
  converter. A stall of the converter loses no word.
  Assumes one clock; out_* come straight from flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none

module aobs_skid (
  input  wire        mclk,
  input  wire        reset,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [17:0] in_data,
  output reg         out_valid_q,
  input  wire        out_ready,
  output reg  [17:0] out_data_q
);

  reg        sp_valid_q;
  reg [17:0] sp_data_q;
  wire       push;
  wire       pop;

  // ============================================================
  // Handshakes
  assign in_ready = ~sp_valid_q;
  assign push     = in_valid & ~sp_valid_q;
  assign pop      = out_valid_q & out_ready;

  // ============================================================
  // Output stage refills from spare first, then from input
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 18'h00000;
      sp_valid_q  <= 1'b0;
      sp_data_q   <= 18'h00000;
    end else if (pop || !out_valid_q) begin
      if (sp_valid_q) begin
        out_valid_q <= 1'b1;
        out_data_q  <= sp_data_q;
        sp_valid_q  <= push;
        if (push) begin
          sp_data_q <= in_data;
        end
      end else begin
        out_valid_q <= push;
        if (push) begin
          out_data_q <= in_data;
        end
      end
    end else if (push) begin
      sp_valid_q <= 1'b1;
      sp_data_q  <= in_data;
    end
  end

endmodule

`default_nettype wire

// *** aobs_top.v ***
/*
  Output buffer sequencer of a two-channel analog output board: AXI4-Lite
  registers, sample buffer, sample clock choice, continuous, circular and
  triggered-burst playback to the converter.
  Assumes all inputs synchronous to mclk and a converter taking words by
  valid/ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aobs_consts.vh"

module aobs_top (
  input  wire        mclk,
  input  wire        reset,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_clk_in,
  input  wire        ext_trigger_in,
  output wire [15:0] dac_data,
  output wire        dac_chan,
  output wire        dac_valid,
  input  wire        dac_ready,
  output reg         irq_q
);

  localparam ST_IDLE = 1'b0;
  localparam ST_PLAY = 1'b1;

  reg  [31:0] bufops_q;
  reg  [31:0] bctl_q;
  reg  [15:0] rate_q;
  reg  [7:0]  aw_addr_q;
  reg         aw_full_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_full_q;
  reg  [15:0] div_q;
  reg         ext_clk_q;
  reg         sync_q;
  reg         ext_pend_q;
  reg         st_q;
  reg  [7:0]  wr_ptr_q;
  reg  [7:0]  rd_ptr_q;
  reg  [7:0]  base_q;
  reg  [8:0]  cnt_q;
  reg         pend_q;
  reg  [31:0] wmask;
  reg  [31:0] rd_val;
  reg         rd_err;
  wire        wr_go;
  wire        wr_bufops;
  wire        wr_bctl;
  wire        wr_rate;
  wire        wr_data;
  wire        circ;
  wire        clk_en;
  wire        burst;
  wire        int_tick;
  wire        tick;
  wire        sync_fall;
  wire        start;
  wire        play_ok;
  wire        empty;
  wire        full;
  wire        mem_we;
  wire        issue;
  wire        burst_end;
  wire [7:0]  rd_inc;
  wire [17:0] mem_q;
  wire        skid_rdy;
  wire [17:0] skid_q;
  wire [3:0]  int_sel;

  // ============================================================
  // Control fields
  assign circ    = bufops_q[`AOBS_BO_CIRC];
  assign clk_en  = bufops_q[`AOBS_BO_EN];
  assign burst   = bctl_q[`AOBS_BC_BURST];
  assign int_sel = bctl_q[`AOBS_BC_INT_HI:`AOBS_BC_INT_LO];

  // ============================================================
  // AXI write decode
  assign wr_go     = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_bufops = wr_go & (aw_addr_q == `AOBS_OFF_BUFOPS);
  assign wr_bctl   = wr_go & (aw_addr_q == `AOBS_OFF_BCTL);
  assign wr_rate   = wr_go & (aw_addr_q == `AOBS_OFF_RATE);
  assign wr_data   = wr_go & (aw_addr_q == `AOBS_OFF_DATA);

  // Byte lanes to bit mask
  always @* begin
    wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
             {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  end

  // Address and data channels latch independently, answer follows both
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AOBS_RESP_OK;
      aw_full_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_full_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q     <= 1'b0;
        w_full_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_bufops | wr_bctl | wr_rate | wr_data) ?
                         `AOBS_RESP_OK : `AOBS_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // Control registers; one write sets clock source, enable, loop
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      bufops_q <= `AOBS_BUFOPS_RST;
      bctl_q   <= `AOBS_BCTL_RST;
      rate_q   <= `AOBS_RATE_RST;
    end else begin
      if (wr_bufops) begin
        bufops_q <= (bufops_q & ~wmask) | (w_data_q & wmask);
      end
      if (burst_end) begin
        bctl_q[`AOBS_BC_TRIG] <= 1'b0;
      end
      if (wr_bctl) begin
        bctl_q <= (bctl_q & ~wmask) | (w_data_q & wmask);
      end
      if (wr_rate) begin
        rate_q <= (rate_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
      end
    end
  end

  // ============================================================
  // AXI read mux
  always @* begin
    rd_err = 1'b0;
    case (s_axi_araddr[7:0])
      `AOBS_OFF_BUFOPS: rd_val = bufops_q;
      `AOBS_OFF_BCTL:   rd_val = bctl_q;
      `AOBS_OFF_RATE:   rd_val = {16'h0000, rate_q};
      `AOBS_OFF_DATA:   rd_val = 32'h0000_0000;
      `AOBS_OFF_STAT:   rd_val = {19'h00000, (st_q == ST_IDLE), st_q,
                                  full, empty, cnt_q};
      default: begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // Read channel, one outstanding read
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AOBS_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_err ? `AOBS_RESP_ERR : `AOBS_RESP_OK;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ============================================================
  // Sample clock: internal divider or rising external clock
  assign int_tick  = (div_q == 16'h0000);
  assign tick      = clk_en & (bufops_q[`AOBS_BO_EXT] ?
                     (ext_clk_in & ~ext_clk_q) : int_tick);
  assign sync_fall = sync_q & ~ext_trigger_in;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_q     <= 16'h0000;
      ext_clk_q <= 1'b0;
      sync_q    <= 1'b1;
    end else begin
      ext_clk_q <= ext_clk_in;
      sync_q    <= ext_trigger_in;
      if (int_tick) begin
        div_q <= ((rate_q < `AOBS_RATE_MIN) ? `AOBS_RATE_MIN : rate_q)
                 - 16'h0001;
      end else begin
        div_q <= div_q - 16'h0001;
      end
    end
  end

  // ============================================================
  // Burst sequencer
  assign start = (st_q == ST_IDLE) & clk_en &
                 (bctl_q[`AOBS_BC_TRIG] | ext_pend_q);
  assign burst_end = burst & (st_q == ST_PLAY) & pend_q &
                     mem_q[`AOBS_DW_EOF];
  assign play_ok = clk_en & (~burst | (st_q == ST_PLAY));

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q       <= ST_IDLE;
      ext_pend_q <= 1'b0;
    end else begin
      if (!burst) begin
        st_q       <= ST_IDLE;
        ext_pend_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (start) begin
              st_q <= ST_PLAY;
            end
          end
          ST_PLAY: begin
            if (burst_end) begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
        // One pending edge per burst; a new edge wins over the take
        if (sync_fall) begin
          ext_pend_q <= 1'b1;
        end else if (start) begin
          ext_pend_q <= 1'b0;
        end
      end
    end
  end

  // ============================================================
  // Buffer pointers; closed loop wraps read to base
  assign empty  = (cnt_q == 9'h000);
  assign full   = (cnt_q == `AOBS_DEPTH);
  assign mem_we = wr_data & ~circ & ~full;
  assign issue  = tick & play_ok & ~empty & skid_rdy & ~pend_q;
  assign rd_inc = rd_ptr_q + 8'h01;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= 8'h00;
      rd_ptr_q <= 8'h00;
      base_q   <= 8'h00;
      cnt_q    <= 9'h000;
      pend_q   <= 1'b0;
    end else begin
      pend_q <= issue;
      if (mem_we) begin
        wr_ptr_q <= wr_ptr_q + 8'h01;
      end
      if (issue && circ && (rd_inc == wr_ptr_q)) begin
        rd_ptr_q <= base_q;
      end else if (issue) begin
        rd_ptr_q <= rd_inc;
      end
      if (!circ) begin
        base_q <= issue ? rd_inc : rd_ptr_q;
      end
      cnt_q <= cnt_q + {8'h00, mem_we} - {8'h00, issue & ~circ};
    end
  end

  // ============================================================
  // Interrupt request level by selection code
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ((int_sel == `AOBS_INT_LOQ) && (cnt_q < `AOBS_QTR))
            || ((int_sel == `AOBS_INT_BRDY) && burst
                && (st_q == ST_IDLE));
    end
  end

  // ============================================================
  // Storage and converter-side buffer
  aobs_mem u_mem (
    .mclk    (mclk),
    .reset   (reset),
    .we      (mem_we),
    .waddr   (wr_ptr_q),
    .wdata   (w_data_q[`AOBS_WW-1:0]),
    .re      (issue),
    .raddr   (rd_ptr_q),
    .rdata_q (mem_q)
  );

  aobs_skid u_skid (
    .mclk        (mclk),
    .reset       (reset),
    .in_valid    (pend_q),
    .in_ready    (skid_rdy),
    .in_data     (mem_q),
    .out_valid_q (dac_valid),
    .out_ready   (dac_ready),
    .out_data_q  (skid_q)
  );

  assign dac_data = skid_q[15:0];
  assign dac_chan = skid_q[`AOBS_DW_CHAN];

endmodule

`default_nettype wire

// *** aobs_top_assertions.sv ***
/*
  Port checker for aobs_top: register bus handshakes and converter link.
  Assumes binding to aobs_top, one clock mclk, reset async active high.
*/
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Checker
module aobs_chk (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] dac_data,
  input wire logic        dac_chan,
  input wire logic        dac_valid,
  input wire logic        dac_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // Write address and data taken at the same edge
  wire logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  property p_dac_hold;
    dac_valid && !dac_ready |=> dac_valid && $stable(dac_data) && $stable(dac_chan);
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("converter word changed before taken");

  property p_rst_quiet;
    $fell(reset) |-> !dac_valid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("converter word right after reset");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped early");

  property p_b_lat;
    wr_go |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write response late");

  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read response late");

  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read address taken during answer");

  property p_unmapped;
    wr_go && s_axi_awaddr[7:0] == 8'h14 |=> ##1 s_axi_bvalid && s_axi_bresp == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped write not refused");

  c_word: cover property (dac_valid && dac_ready);
  c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind aobs_top aobs_chk aobs_chk_i (
  .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .dac_data, .dac_chan, .dac_valid,
  .dac_ready
);

`default_nettype wire

// *** aobs_top_tb.sv ***
/*
  Self-checking bench of aobs_top: register bus, continuous, circular,
  burst and external clock playback.
  Assumes aobs_top, aobs_conv and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aobs_consts.vh"

// ============================================================
// Bench
module aobs_top_tb;
  logic mclk = 0, reset = 1, stall = 0, ext_clk_in = 0, ext_trigger_in = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rdat;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, dac_ready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata;
  logic [15:0] dac_data;
  logic dac_chan, dac_valid, irq_q;
  logic [17:0] q[$];
  int miscompares = 0, checks = 0, i;

  aobs_top aobs_top_i (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_in,
    .ext_trigger_in, .dac_data, .dac_chan, .dac_valid, .dac_ready, .irq_q);
  aobs_conv aobs_conv_i (.mclk, .reset, .stall_en(stall), .dac_data, .dac_chan,
    .dac_valid, .dac_ready);

  // Clock at 25 MHz
  initial begin
    forever #20 mclk = ~mclk;
  end

  // Word seen by the converter for a buffer word
  function automatic logic [31:0] ex(input logic [17:0] w);
    return {15'h0, w[17], w[15:0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic rst;
    reset <= 1'b1;
    q.delete();
    wt(6);
    reset <= 1'b0;
  endtask

  // Bus write, response ready raised at random and then held
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_bready) s_axi_bready <= 1'($urandom);
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'($urandom);
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Load a buffer word and remember it
  task automatic ld(input logic [17:0] w);
    q.push_back(w);
    wr(`AOBS_OFF_DATA, {14'h0, w});
  endtask

  task automatic wn(input int n);
    for (int k = 0; k < 3000 && aobs_conv_i.got.size() < n; k++) @(posedge mclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    wt(40000);
    miscompares++;
    give_verdict;
  end

  // Test sequence
  initial begin
    void'($urandom(32'h3bec));
    rst;
    rd(`AOBS_OFF_BUFOPS);
    chk("bufops", `AOBS_BUFOPS_RST, rdat);
    rd(`AOBS_OFF_RATE);
    chk("rate", {16'h0, `AOBS_RATE_RST}, rdat);
    rd(`AOBS_OFF_STAT);
    chk("status", 32'h0000_1200, rdat);
    wr(8'h14, 32'h1);
    chk("bresp", {30'h0, `AOBS_RESP_ERR}, {30'h0, rsp});
    rd(8'h14);
    chk("rresp", {30'h0, `AOBS_RESP_ERR}, {30'h0, rsp});
    $display("test reset done");

    rst;
    wr(`AOBS_OFF_RATE, 32'ha);
    chk("bresp ok", {30'h0, `AOBS_RESP_OK}, {30'h0, rsp});
    wr(`AOBS_OFF_BCTL, 32'h300);
    // First block is one quarter of the buffer
    for (i = 0; i < 64; i++) ld({1'($urandom), 1'b0, 16'($urandom)});
    wt(2);
    chk("irq quarter full", 0, {31'h0, irq_q});
    wr(`AOBS_OFF_BUFOPS, 32'h20);
    wt(100);
    i = aobs_conv_i.got.size();
    chk("rate count", 1, {31'h0, i >= 9 && i <= 11});
    chk("irq lo quarter", 1, {31'h0, irq_q});
    // Interrupt served at once, next block lands long before empty
    for (i = 0; i < 64; i++) ld({1'($urandom), 1'b0, 16'($urandom)});
    wn(128);
    for (i = 0; i < 128; i++) chk("word", ex(q[i]), {15'h0, aobs_conv_i.got[i]});
    $display("test continuous done");

    rst;
    stall <= 1'b1;
    wr(`AOBS_OFF_RATE, 32'h2);
    for (i = 0; i < 3; i++) ld({1'($urandom), 1'b0, 16'($urandom)});
    wr(`AOBS_OFF_BUFOPS, 32'h120);
    wr(`AOBS_OFF_DATA, 32'h1ffff);
    chk("drop resp", {30'h0, `AOBS_RESP_OK}, {30'h0, rsp});
    wn(9);
    for (i = 0; i < 9; i++) chk("loop", ex(q[i % 3]), {15'h0, aobs_conv_i.got[i]});
    stall <= 1'b0;
    $display("test circular done");

    rst;
    wr(`AOBS_OFF_RATE, 32'h2);
    for (i = 0; i < 5; i++) ld({1'($urandom), i == 1 || i == 4, 16'($urandom)});
    wr(`AOBS_OFF_BCTL, 32'h501);
    wr(`AOBS_OFF_BUFOPS, 32'h20);
    wt(30);
    chk("idle", 0, 32'(aobs_conv_i.got.size()));
    chk("irq ready", 1, {31'h0, irq_q});
    wr(`AOBS_OFF_BCTL, 32'h505);
    wn(2);
    wt(30);
    chk("burst one", 2, 32'(aobs_conv_i.got.size()));
    rd(`AOBS_OFF_BCTL);
    chk("trigger clear", 32'h501, rdat);
    ext_trigger_in <= 1'b0;
    wn(5);
    wt(30);
    ext_trigger_in <= 1'b1;
    chk("burst two", 5, 32'(aobs_conv_i.got.size()));
    for (i = 0; i < 5; i++) chk("burst", ex(q[i]), {15'h0, aobs_conv_i.got[i]});
    $display("test burst done");

    // Circular burst mode: bursts of one and two words cycle without reload
    rst;
    wr(`AOBS_OFF_RATE, 32'h2);
    for (i = 0; i < 3; i++) ld({1'($urandom), i != 1, 16'($urandom)});
    wr(`AOBS_OFF_BCTL, 32'h1);
    wr(`AOBS_OFF_BUFOPS, 32'h120);
    wr(`AOBS_OFF_BCTL, 32'h5);
    wn(1);
    wr(`AOBS_OFF_BCTL, 32'h5);
    wn(3);
    wr(`AOBS_OFF_BCTL, 32'h5);
    wn(4);
    wt(20);
    chk("cycle count", 4, 32'(aobs_conv_i.got.size()));
    for (i = 0; i < 4; i++) chk("cycle", ex(q[i % 3]), {15'h0, aobs_conv_i.got[i]});
    $display("test circular burst done");

    rst;
    wr(`AOBS_OFF_RATE, 32'h2);
    for (i = 0; i < 4; i++) ld({1'($urandom), 1'b0, 16'($urandom)});
    wr(`AOBS_OFF_BUFOPS, 32'h30);
    wt(40);
    chk("no internal", 0, 32'(aobs_conv_i.got.size()));
    repeat (3) begin
      ext_clk_in <= 1'b1;
      wt(4);
      ext_clk_in <= 1'b0;
      wt(4);
    end
    wt(10);
    chk("ext ticks", 3, 32'(aobs_conv_i.got.size()));
    $display("test external clock done");
    give_verdict;
  end
endmodule

`default_nettype wire
